//--- hw/twm_pkg.sv
// Purpose: Shared constants for the two-wire master status engine.
// Assumes: 50 MHz system clock, 100 kHz bus bit rate.
// Notes:   One bus bit is four quarter periods.
package twm_pkg;
   localparam int CLK_NS      = 20;
   localparam int QTR_NS      = 2500;
   localparam int QTR_CYC     = (QTR_NS + CLK_NS - 1) / CLK_NS;
   localparam int DATA_W      = 8;
   localparam int TXQ_DEPTH   = 4;
   localparam logic [6:0] QTR_LAST = 7'(QTR_CYC - 1);
   localparam logic [3:0] ACK_SLOT = 4'h8;

   localparam logic [7:0] ST_START  = 8'h08;
   localparam logic [7:0] ST_RSTART = 8'h10;
   localparam logic [7:0] ST_AW_ACK = 8'h18;
   localparam logic [7:0] ST_AW_NAK = 8'h20;
   localparam logic [7:0] ST_DT_ACK = 8'h28;
   localparam logic [7:0] ST_DT_NAK = 8'h30;
   localparam logic [7:0] ST_ARB    = 8'h38;
   localparam logic [7:0] ST_AR_ACK = 8'h40;
   localparam logic [7:0] ST_AR_NAK = 8'h48;
   localparam logic [7:0] ST_RX_ACK = 8'h50;
   localparam logic [7:0] ST_RX_NAK = 8'h58;
   localparam logic [7:0] ST_IDLE   = 8'hf8;

   typedef enum logic [6:0] {
      S_IDLE   = 7'h01,
      S_START  = 7'h02,
      S_RSTART = 7'h04,
      S_STOP   = 7'h08,
      S_TX     = 7'h10,
      S_RX     = 7'h20,
      S_HOLD   = 7'h40
   } twm_state_type;
endpackage : twm_pkg

//--- hw/twm_master_engine.sv
// Purpose: Master transmitter/receiver sequencing of a two-wire serial unit.
// Assumes: Open-drain pins are resolved outside; oe high means pull low.
// Notes:   Bytes to send are queued in a small FIFO ahead of the engine.
// Notes on behaviour
// - After start post 08, then send address.
// - After repeated start post 10; read address.
// - Write address at 10 selects transmitter role.
// - Post 18 on acked write address.
// - Post 20 on nacked write address.
// - Post 28 on acked data byte.
// - Post 30 on nacked data byte.
// - Start-request alone makes repeated start.
// - Stop-request alone makes stop, clears itself.
// - Both requests: stop then start, clear stop.
// - Arbitration loss posts 38, releases bus.
// - Start-request after loss waits bus free.
// - Loss during own acknowledge posts 38.
// - At 08 firmware loads read address.
// - Post 40; acknowledge follows ack-enable.
// - Post 48 then honour start/stop requests.
// - Post 50; ack-enable steers next acknowledge.
// - Post 58; firmware picks start/stop.
// - Transfer suspended while flag is set.
`timescale 1ns/1ns

module twm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0]      cnt_r, cnt_nxt;
   logic             push, pop;

   assign inReady  = cnt_r != (AW+1)'(DEPTH);
   assign outValid = cnt_r != '0;
   assign outData  = mem_r[rp_r];

   always_comb begin
      push    = inValid && inReady;
      pop     = outValid && outReady;
      wp_nxt  = push ? AW'((wp_r + 1'b1) % DEPTH) : wp_r;
      rp_nxt  = pop ? AW'((rp_r + 1'b1) % DEPTH) : rp_r;
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
         cnt_r <= cnt_nxt;
         if (push) begin
            mem_r[wp_r] <= inData;
         end
      end
   end
endmodule : twm_fifo

module twm_master_engine
   import twm_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        sclIn,
   output logic             sclOut,
   output logic             sclOe,
   input  wire logic        sdaIn,
   output logic             sdaOut,
   output logic             sdaOe,
   input  wire logic        txValid,
   output logic             txReady,
   input  wire logic [7:0]  txData,
   input  wire logic        ctrlWr,
   input  wire logic        ctrlSta,
   input  wire logic        ctrlSto,
   input  wire logic        ctrlAck,
   output logic             siFlag,
   output logic      [7:0]  statusCode,
   output logic      [7:0]  rxData,
   output logic             startReq,
   output logic             stopReq,
   output logic             receiverRole,
   output logic             busBusy
);
   twm_state_type state_r, state_nxt;
   logic [6:0] div_r, div_nxt;
   logic [1:0] q_r, q_nxt;
   logic [3:0] bit_r, bit_nxt;
   logic [7:0] shift_r, shift_nxt, stat_r, stat_nxt, rxd_r, rxd_nxt;
   logic       sclLow_r, sclLow_nxt, sdaLow_r, sdaLow_nxt;
   logic       si_r, si_nxt, sta_r, sta_nxt, sto_r, sto_nxt;
   logic       ack_r, ack_nxt, ackIn_r, ackIn_nxt;
   logic       role_r, role_nxt, addr_r, addr_nxt, busy_r, busy_nxt;
   logic       sclSy1_r, sclS_r, sdaSy1_r, sdaS_r, sdaD_r;
   logic       tick, qAdv, post, pop, qValid, lost;
   logic [7:0] postCode, qData;

   twm_fifo #(.WIDTH(DATA_W), .DEPTH(TXQ_DEPTH)) u_txq (
      .clk      (clk),
      .rst_b    (rst_b),
      .inValid  (txValid),
      .inReady  (txReady),
      .inData   (txData),
      .outValid (qValid),
      .outReady (pop),
      .outData  (qData)
   );

   assign sclOut       = 1'b0;
   assign sdaOut       = 1'b0;
   assign sclOe        = sclLow_r;
   assign sdaOe        = sdaLow_r;
   assign siFlag       = si_r;
   assign statusCode   = stat_r;
   assign rxData       = rxd_r;
   assign startReq     = sta_r;
   assign stopReq      = sto_r;
   assign receiverRole = role_r;
   assign busBusy      = busy_r;
   assign tick         = div_r == QTR_LAST;

   // Pins are asynchronous; only the second stage and later are read.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sclSy1_r <= 1'b1;
         sclS_r   <= 1'b1;
         sdaSy1_r <= 1'b1;
         sdaS_r   <= 1'b1;
         sdaD_r   <= 1'b1;
      end else begin
         sclSy1_r <= sclIn;
         sclS_r   <= sclSy1_r;
         sdaSy1_r <= sdaIn;
         sdaS_r   <= sdaSy1_r;
         sdaD_r   <= sdaS_r;
      end
   end

   always_comb begin
      state_nxt  = state_r;
      div_nxt    = tick ? '0 : div_r + 7'h01;
      q_nxt      = q_r;
      bit_nxt    = bit_r;
      shift_nxt  = shift_r;
      stat_nxt   = stat_r;
      rxd_nxt    = rxd_r;
      sclLow_nxt = sclLow_r;
      sdaLow_nxt = sdaLow_r;
      si_nxt     = si_r;
      sta_nxt    = sta_r;
      sto_nxt    = sto_r;
      ack_nxt    = ack_r;
      ackIn_nxt  = ackIn_r;
      role_nxt   = role_r;
      addr_nxt   = addr_r;
      busy_nxt   = busy_r;
      post       = 1'b0;
      postCode   = stat_r;
      pop        = 1'b0;
      lost       = 1'b0;
      // Quarters wait at the high phase while a slave stretches the clock.
      qAdv       = tick && (q_r != 2'h2 || sclS_r);
      if (sclS_r && sdaD_r && !sdaS_r) begin
         busy_nxt = 1'b1;
      end else if (sclS_r && !sdaD_r && sdaS_r) begin
         busy_nxt = 1'b0;
      end
      if (qAdv) begin
         q_nxt = q_r + 2'h1;
      end
      unique case (state_r)
         S_IDLE: begin
            div_nxt = '0;
            q_nxt   = '0;
            if (sta_r && !busy_r) begin
               state_nxt = S_START;
            end
         end
         S_START: begin
            if (qAdv) begin
               unique case (q_r)
                  2'h0: begin
                     sclLow_nxt = 1'b0;
                     sdaLow_nxt = 1'b0;
                  end
                  2'h1: sdaLow_nxt = 1'b1;
                  default: begin
                     sclLow_nxt = 1'b1;
                     post       = 1'b1;
                     postCode   = ST_START;
                  end
               endcase
            end
         end
         S_RSTART, S_STOP: begin
            if (qAdv) begin
               unique case (q_r)
                  2'h0: sdaLow_nxt = state_r == S_RSTART ? 1'b0 : 1'b1;
                  2'h1: sclLow_nxt = 1'b0;
                  2'h2: sdaLow_nxt = state_r == S_RSTART;
                  default: begin
                     if (state_r == S_RSTART) begin
                        sclLow_nxt = 1'b1;
                        post       = 1'b1;
                        postCode   = ST_RSTART;
                     end else begin
                        state_nxt = S_IDLE;
                        role_nxt  = 1'b0;
                     end
                  end
               endcase
            end
         end
         S_TX, S_RX: begin
            if (qAdv) begin
               unique case (q_r)
                  2'h0: begin
                     if (bit_r == ACK_SLOT) begin
                        sdaLow_nxt = state_r == S_RX && ack_r;
                     end else begin
                        sdaLow_nxt = state_r == S_TX && !shift_r[7];
                     end
                  end
                  2'h1: sclLow_nxt = 1'b0;
                  2'h2: begin
                     // A released line read low on a sent data bit or on our own acknowledge means another master won.
                     lost = !sdaLow_r && !sdaS_r &&
                            ((state_r == S_TX) != (bit_r == ACK_SLOT));
                     if (lost) begin
                        sdaLow_nxt = 1'b0;
                        role_nxt   = 1'b0;
                        post       = 1'b1;
                        postCode   = ST_ARB;
                     end else if (bit_r == ACK_SLOT) begin
                        ackIn_nxt = sdaS_r;
                     end else begin
                        shift_nxt = {shift_r[6:0], sdaS_r};
                     end
                  end
                  default: begin
                     sclLow_nxt = 1'b1;
                     bit_nxt    = bit_r + 4'h1;
                     if (bit_r == ACK_SLOT) begin
                        post = 1'b1;
                        if (state_r == S_RX) begin
                           rxd_nxt  = shift_r;
                           postCode = ackIn_r ? ST_RX_NAK : ST_RX_ACK;
                        end else if (!addr_r) begin
                           postCode = ackIn_r ? ST_DT_NAK : ST_DT_ACK;
                        end else if (shift_r[0]) begin
                           role_nxt = 1'b1;
                           postCode = ackIn_r ? ST_AR_NAK : ST_AR_ACK;
                        end else begin
                           role_nxt = 1'b0;
                           postCode = ackIn_r ? ST_AW_NAK : ST_AW_ACK;
                        end
                     end
                  end
               endcase
            end
         end
         default: begin
            div_nxt = '0;
            q_nxt   = '0;
            bit_nxt = '0;
            if (!si_r) begin
               if (stat_r == ST_START || stat_r == ST_RSTART) begin
                  if (qValid) begin
                     pop       = 1'b1;
                     shift_nxt = qData;
                     addr_nxt  = 1'b1;
                     state_nxt = S_TX;
                  end
               end else if (stat_r == ST_ARB) begin
                  sclLow_nxt = 1'b0;
                  state_nxt  = S_IDLE;
               end else if (sto_r) begin
                  sto_nxt   = 1'b0;
                  state_nxt = S_STOP;
               end else if (sta_r) begin
                  state_nxt = S_RSTART;
               end else if (stat_r == ST_AR_ACK || stat_r == ST_RX_ACK) begin
                  state_nxt = S_RX;
               end else if (stat_r != ST_AR_NAK && stat_r != ST_RX_NAK &&
                            qValid) begin
                  pop       = 1'b1;
                  shift_nxt = qData;
                  addr_nxt  = 1'b0;
                  state_nxt = S_TX;
               end
            end
         end
      endcase
      if (post) begin
         si_nxt    = 1'b1;
         stat_nxt  = postCode;
         state_nxt = S_HOLD;
      end
      if (ctrlWr) begin
         sta_nxt = ctrlSta;
         sto_nxt = ctrlSto;
         ack_nxt = ctrlAck;
         if (!post) begin
            si_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_r  <= S_IDLE;
         div_r    <= '0;
         q_r      <= '0;
         bit_r    <= '0;
         shift_r  <= '0;
         stat_r   <= ST_IDLE;
         rxd_r    <= '0;
         sclLow_r <= 1'b0;
         sdaLow_r <= 1'b0;
         si_r     <= 1'b0;
         sta_r    <= 1'b0;
         sto_r    <= 1'b0;
         ack_r    <= 1'b0;
         ackIn_r  <= 1'b1;
         role_r   <= 1'b0;
         addr_r   <= 1'b0;
         busy_r   <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         div_r    <= div_nxt;
         q_r      <= q_nxt;
         bit_r    <= bit_nxt;
         shift_r  <= shift_nxt;
         stat_r   <= stat_nxt;
         rxd_r    <= rxd_nxt;
         sclLow_r <= sclLow_nxt;
         sdaLow_r <= sdaLow_nxt;
         si_r     <= si_nxt;
         sta_r    <= sta_nxt;
         sto_r    <= sto_nxt;
         ack_r    <= ack_nxt;
         ackIn_r  <= ackIn_nxt;
         role_r   <= role_nxt;
         addr_r   <= addr_nxt;
         busy_r   <= busy_nxt;
      end
   end

   start_post_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state_r == S_START && qAdv && q_r == 2'h2) |=> si_r && stat_r == ST_START)
      else $error("start did not post its code");
   rstart_post_a: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(state_r == S_RSTART) |-> si_r && stat_r == ST_RSTART)
      else $error("repeated start did not post its code");
   hold_still_a: assert property (@(posedge clk) disable iff (!rst_b)
      si_r |=> $stable(sclLow_r) && $stable(sdaLow_r) && state_r == S_HOLD)
      else $error("bus moved while flag set");
   rs_choice_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state_r == S_HOLD && !si_r && sta_r && !sto_r && stat_r != ST_START &&
       stat_r != ST_RSTART && stat_r != ST_ARB) |=> state_r == S_RSTART)
      else $error("repeated start not chosen");
   stop_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state_r == S_HOLD && !si_r && sto_r && !ctrlWr && stat_r != ST_START &&
       stat_r != ST_RSTART && stat_r != ST_ARB) |=> state_r == S_STOP && !sto_r)
      else $error("stop not issued or not cleared");
   free_start_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state_r == S_IDLE && sta_r && !busy_r) |=> state_r == S_START)
      else $error("start not begun on free bus");
   arb_post_a: assert property (@(posedge clk) disable iff (!rst_b)
      lost |=> stat_r == ST_ARB && si_r && !sdaLow_r && !role_r)
      else $error("arbitration loss not handled");
   ack_drive_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state_r == S_RX && bit_r == ACK_SLOT && qAdv && q_r == 2'h0)
      |=> sdaLow_r == $past(ack_r))
      else $error("acknowledge does not follow ack-enable");
endmodule : twm_master_engine

//--- sim/twm_slave_model.sv
// Purpose: Behavioural slave on the open-drain two-wire bus.
// Assumes: Pull-ups on both lines; the line levels come in resolved.
// Notes:   Answers one address; nakAll makes it refuse every byte.
`timescale 1ns/1ns
module twm_slave_model #(
   parameter logic [6:0] ADDR = 7'h2a
) (
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       nakAll,
   input  wire logic [7:0] readByte,
   output logic            sdaPull
);
   int         bitCnt;
   logic [7:0] shift;
   logic       isAddr;
   logic       reading;

   initial begin
      sdaPull = 0;
      bitCnt = 0;
      isAddr = 0;
      reading = 0;
      shift = 8'h00;
   end

   always @(negedge sda) begin
      if (scl) begin
         bitCnt = 0;
         isAddr = 1;
         reading = 0;
      end
   end

   always @(posedge sda) begin
      if (scl) begin
         isAddr = 0;
         reading = 0;
      end
   end

   always @(posedge scl) begin
      if (bitCnt < 8) begin
         shift = {shift[6:0], sda};
      end else if (reading && sda) begin
         reading = 0;
      end
      bitCnt++;
   end

   // Line changes land just after the clock falls, never while it is high.
   always @(negedge scl) begin
      #1;
      if (bitCnt == 8) begin
         if (!reading) begin
            sdaPull = !nakAll && (!isAddr || shift[7:1] == ADDR);
            if (isAddr && sdaPull) begin
               reading = shift[0];
            end
         end else begin
            sdaPull = 0;
         end
      end else begin
         if (bitCnt == 9) begin
            bitCnt = 0;
            isAddr = 0;
         end
         sdaPull = reading ? ~readByte[7 - bitCnt] : 1'b0;
      end
   end
endmodule : twm_slave_model

//--- sim/tb.sv
// Purpose: Self-checking bench for the two-wire master engine.
// Assumes: Pull-ups on both lines; one slave model and a rival master pull.
// Notes:   Ordinary steps are table rows; stop, arbitration and FIFO are by hand.
`timescale 1ns/1ns
module tb;
   import twm_pkg::*;
   typedef struct {logic start_request; logic stop_request; logic ack; logic doPush; logic [7:0] txB;
                   logic nak; logic [7:0] code; logic role;} twm_row_type;
   logic       clk, rst_b, txValid, ctrlWr, ctrlSta, ctrlSto, ctrlAck, nakAll, rivalPull;
   logic [7:0] txData;
   logic [7:0] rdByte = 8'hc3;
   wire logic  sclOe, sdaOe, siFlag, startReq, stopReq, receiverRole, busBusy, txReady;
   wire logic  slvPull;
   wire logic [7:0] statusCode, rxData;
   wire logic  scl = ~sclOe;
   wire logic  sda = ~(sdaOe | slvPull | rivalPull);
   int         n_errors = 0;
   int         total_checks = 0;
   twm_row_type rows[14] = '{
      '{1,0,0,0,8'h00,0,ST_START,0},  '{0,0,0,1,8'h54,0,ST_AW_ACK,0},
      '{0,0,0,1,8'ha5,0,ST_DT_ACK,0}, '{0,0,0,1,8'h3c,1,ST_DT_NAK,0},
      '{1,0,0,0,8'h00,0,ST_RSTART,0}, '{0,0,1,1,8'h55,0,ST_AR_ACK,1},
      '{0,0,1,0,8'h00,0,ST_RX_ACK,1}, '{0,0,0,0,8'h00,0,ST_RX_NAK,1},
      '{1,0,0,0,8'h00,0,ST_RSTART,1}, '{0,0,0,1,8'h54,0,ST_AW_ACK,0},
      '{1,1,0,0,8'h00,0,ST_START,0},  '{0,0,0,1,8'h20,0,ST_AW_NAK,0},
      '{1,0,0,0,8'h00,0,ST_RSTART,0}, '{0,0,0,1,8'h21,0,ST_AR_NAK,1}};

   twm_master_engine dut (.clk(clk), .rst_b(rst_b), .sclIn(scl), .sclOut(), .sclOe(sclOe),
      .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe), .txValid(txValid), .txReady(txReady),
      .txData(txData), .ctrlWr(ctrlWr), .ctrlSta(ctrlSta), .ctrlSto(ctrlSto),
      .ctrlAck(ctrlAck), .siFlag(siFlag), .statusCode(statusCode), .rxData(rxData),
      .startReq(startReq), .stopReq(stopReq), .receiverRole(receiverRole), .busBusy(busBusy));

   twm_slave_model slave (.scl(scl), .sda(sda), .nakAll(nakAll), .readByte(rdByte),
      .sdaPull(slvPull));

   task automatic close_out();
      $display("Checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : tick

   task automatic ctrl(input logic start_request, input logic stop_request, input logic ack);
      ctrlSta = start_request;
      ctrlSto = stop_request;
      ctrlAck = ack;
      ctrlWr = 1;
      tick(1);
      ctrlWr = 0;
   endtask : ctrl

   task automatic push(input logic [7:0] b);
      int i;
      txData = b;
      txValid = 1;
      for (i = 0; i < 50 && txReady !== 1'b1; i++) tick(1);
      if (txReady !== 1'b1) begin
         check("txReady timeout", txReady, 8'h01);
         close_out();
      end
      tick(1);
      txValid = 0;
      tick(1);
   endtask : push

   // The flag must stay up and the clock line frozen while firmware is away.
   task automatic wait_flag(input logic [7:0] code);
      int   i;
      logic oeS;
      for (i = 0; i < 20000 && siFlag !== 1'b1; i++) tick(1);
      if (siFlag !== 1'b1) begin
         check("siFlag timeout", siFlag, 8'h01);
         close_out();
      end
      check("statusCode", statusCode, code);
      oeS = sclOe;
      tick(100);
      check("held flag", {siFlag, sclOe}, {1'b1, oeS});
   endtask : wait_flag

   initial begin
      clk = 0;
      forever #10 clk = ~clk;
   end

   initial begin
      rst_b = 0;
      txValid = 0;
      ctrlWr = 0;
      ctrlSta = 0;
      ctrlSto = 0;
      ctrlAck = 0;
      txData = 8'h00;
      nakAll = 0;
      rivalPull = 0;
      tick(10);
      check("reset lines", {sclOe, sdaOe, siFlag, busBusy, txReady}, 8'h01);
      check("reset status", statusCode, ST_IDLE);
      rst_b = 1;
      $display("Reset test done");
      foreach (rows[k]) begin
         nakAll = rows[k].nak;
         if (rows[k].doPush) push(rows[k].txB);
         ctrl(rows[k].start_request, rows[k].stop_request, rows[k].ack);
         wait_flag(rows[k].code);
         if (rows[k].code inside {ST_AW_ACK, ST_AR_ACK, ST_RX_ACK}) begin
            check("role", receiverRole, rows[k].role);
         end
         if (rows[k].code inside {ST_RX_ACK, ST_RX_NAK}) begin
            check("rxData", rxData, rdByte);
         end
         $display("Row %0d done", k);
      end
      ctrl(0, 1, 0);
      tick(2000);
      check("stop", {siFlag, stopReq, startReq, busBusy, sclOe, sdaOe}, 8'h00);
      $display("Stop test done");
      ctrl(1, 0, 0);
      wait_flag(ST_START);
      push(8'hfe);
      rivalPull = 1;
      ctrl(0, 0, 0);
      wait_flag(ST_ARB);
      check("released", {sclOe, sdaOe}, 8'h00);
      ctrl(1, 0, 0);
      tick(1000);
      check("start waits", {siFlag, busBusy, startReq}, 8'h03);
      rivalPull = 0;
      wait_flag(ST_START);
      $display("Arbitration test done");
      repeat (4) push(8'h54);
      check("fifo full", txReady, 8'h00);
      ctrl(0, 0, 0);
      wait_flag(ST_AW_ACK);
      repeat (3) begin
         ctrl(0, 0, 0);
         wait_flag(ST_DT_ACK);
      end
      check("fifo empty", txReady, 8'h01);
      $display("FIFO test done");
      // A rival holds data low, so the released acknowledge slot reads low.
      ctrl(1, 0, 0);
      wait_flag(ST_RSTART);
      push(8'h55);
      ctrl(0, 0, 0);
      wait_flag(ST_AR_ACK);
      rivalPull = 1;
      ctrl(0, 0, 0);
      wait_flag(ST_ARB);
      check("rx released", {sclOe, sdaOe, receiverRole}, 8'h00);
      rivalPull = 0;
      $display("Receiver loss test done");
      close_out();
   end
endmodule : tb
